// file: adc_model.sv
module adc_model (
  input wire logic i_bclk,
  input wire logic i_word_select_clock,
  output logic o_sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] word_reg = 16'ha5c3; // Sample being shifted out
  logic lr_reg = 1'b0; // Word select at last bit
  // Data moves on bit clock fall, MSB first, so the receiver samples mid-bit
  always @(negedge i_bclk) begin
    if (i_word_select_clock != lr_reg) begin
      word_reg <= {word_reg[14:0], word_reg[15]} ^ 16'h0101;
    end else begin
      word_reg <= {word_reg[14:0], ~word_reg[15]};
    end
    lr_reg <= i_word_select_clock;
  end
  assign o_sdata = word_reg[15];
endmodule // adc_model

// file: voice_capture_codec_path.sv
module voice_capture_codec_path (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire voice_pkg::reg_req_t i_req,
  input wire voice_pkg::i2s_clk_t i_tx_clk,
  input wire logic i_ext_bclk,
  input wire logic i_ext_word_select_clock,
  input wire logic i_adc_sdata,
  input wire voice_pkg::byte_strm_t i_dec_in,
  input wire logic i_dma_ready,
  output logic [7:0] o_rdata,
  output voice_pkg::i2s_clk_t o_clk,
  output logic o_clk_oe,
  output voice_pkg::byte_strm_t o_dma,
  output voice_pkg::sample_t o_dec
);
  // G.711 mu-law compressor, 14-bit magnitude domain
  function automatic logic [7:0] mu_enc(input logic [15:0] x);
    logic [13:0] m;
    logic [12:0] b;
    logic [2:0] e;
    m = x[15] ? (~x[15:2]) + 14'h0001 : x[15:2];
    if (m > voice_pkg::MU_CLIP) m = voice_pkg::MU_CLIP;
    b = 13'(m + voice_pkg::MU_ADD);
    e = 3'h0;
    for (int i = 1; i < 8; i++) if (b[i + 5]) e = 3'(i);
    return ~{x[15], e, 4'(b >> (4'(e) + 4'h1))};
  endfunction

  // G.711 mu-law expander
  function automatic logic [15:0] mu_dec(input logic [7:0] c);
    logic [7:0] u;
    logic [15:0] t;
    u = ~c;
    t = {8'h00, 8'({u[3:0], 3'h0}) + 8'h84} << u[6:4];
    return u[7] ? 16'(voice_pkg::MU_BIAS - t) : 16'(t - voice_pkg::MU_BIAS);
  endfunction

  // G.711 A-law compressor, 13-bit magnitude domain
  function automatic logic [7:0] a_enc(input logic [15:0] x);
    logic [12:0] m;
    logic [3:0] s;
    m = x[15] ? ~x[15:3] : x[15:3];
    s = 4'h0;
    for (int i = 1; i < 9; i++) if (m >= (13'h0010 << i)) s = 4'(i);
    if (s == 4'h8) return {~x[15], 7'h7f} ^ voice_pkg::A_XOR;
    return {~x[15], s[2:0], (s < 4'h2) ? m[4:1] : 4'(m >> s)} ^ voice_pkg::A_XOR;
  endfunction

  // G.711 A-law expander
  function automatic logic [15:0] a_dec(input logic [7:0] c);
    logic [7:0] a;
    logic [15:0] t;
    a = c ^ voice_pkg::A_XOR;
    t = {8'h00, a[3:0], 4'h0};
    if (a[6:4] == 3'h0) t = t + 16'h0008;
    else t = (t + 16'h0108) << (a[6:4] - 3'h1);
    return a[7] ? t : 16'(-t);
  endfunction

  // Software registers
  logic [7:0] link_reg, sdiv_reg, mdiv_reg, bdiv_reg, mode_reg;
  logic [7:0] encc_reg, ehi_reg, elo_reg, decc_reg, dhi_reg, dlo_reg;
  logic [7:0] tsil_reg;
  logic tmute_reg;
  logic wr, rd;
  assign wr = i_req.wr;
  assign rd = i_req.rd;

  // Register writes; pointer reset bits are pulses, never stored
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      link_reg <= voice_pkg::RST_LINK;
      mode_reg <= voice_pkg::RST_MODE;
      {sdiv_reg, mdiv_reg, bdiv_reg} <= {3{voice_pkg::RST_ZERO}};
      {encc_reg, ehi_reg, elo_reg} <= {3{voice_pkg::RST_ZERO}};
      {decc_reg, dhi_reg, dlo_reg} <= {3{voice_pkg::RST_ZERO}};
      tsil_reg <= voice_pkg::RST_ZERO;
      tmute_reg <= 1'b0;
    end else if (wr) begin
      unique case (i_req.addr)
        voice_pkg::A_RX_LINK: link_reg <= i_req.wdata;
        voice_pkg::A_RX_SDIV: sdiv_reg <= i_req.wdata;
        voice_pkg::A_RX_MDIV: mdiv_reg <= i_req.wdata;
        voice_pkg::A_RX_BDIV: bdiv_reg <= i_req.wdata;
        voice_pkg::A_RX_MODE: mode_reg <= i_req.wdata;
        voice_pkg::A_ENC_CTL: encc_reg <= i_req.wdata & ~(8'h01 << voice_pkg::CC_INI);
        voice_pkg::A_ENC_SHI: ehi_reg <= i_req.wdata;
        voice_pkg::A_ENC_SLO: elo_reg <= i_req.wdata;
        voice_pkg::A_DEC_CTL: decc_reg <= i_req.wdata & ~(8'h01 << voice_pkg::CC_INI);
        voice_pkg::A_DEC_SHI: dhi_reg <= i_req.wdata;
        voice_pkg::A_DEC_SLO: dlo_reg <= i_req.wdata;
        voice_pkg::A_TXF_SIL: tsil_reg <= i_req.wdata;
        voice_pkg::A_TXF_CTL: tmute_reg <= i_req.wdata[voice_pkg::FC_MUTE];
        default: ;
      endcase
    end
  end

  // Decoded control fields
  logic master, share, rx_on, dsp, enc_ini, dec_ini;
  assign master = link_reg[voice_pkg::LK_MASTER];
  assign share = !master && mode_reg[voice_pkg::MD_SHARE];
  assign rx_on = mode_reg[voice_pkg::MD_ON];
  assign dsp = link_reg[voice_pkg::LK_FMT +: 2] == voice_pkg::FMT_DSP;
  assign enc_ini = wr && i_req.addr == voice_pkg::A_ENC_CTL && i_req.wdata[voice_pkg::CC_INI];
  assign dec_ini = wr && i_req.addr == voice_pkg::A_DEC_CTL && i_req.wdata[voice_pkg::CC_INI];

  // Pin synchronisers, two flops each
  logic sd1, sd2, eb1, eb2, el1, el2;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) {sd1, sd2, eb1, eb2, el1, el2} <= 6'h00;
    else {sd1, sd2, eb1, eb2, el1, el2} <= {i_adc_sdata, sd1, i_ext_bclk, eb1, i_ext_word_select_clock, el1};
  end

  // Generated and effective link clocks
  logic mclk_reg, bclk_reg, word_select_clock_reg, mclk_q, bclk_q, word_select_clock_q;
  logic [7:0] mcnt_reg, bcnt_reg, lcnt_reg, lcnt_next;
  logic eff_mclk, eff_bclk, eff_word_select_clock, m_rise, m_edge, b_rise, b_fall, lr_tick;
  always_comb begin
    // Shared slave borrows the transmit block clocks
    eff_mclk = share ? i_tx_clk.mclk : mclk_reg;
    eff_bclk = master ? bclk_reg : (share ? i_tx_clk.bclk : eb2);
    eff_word_select_clock = master ? word_select_clock_reg : (share ? i_tx_clk.word_select_clock : el2);
  end
  assign m_rise = eff_mclk && !mclk_q;
  assign m_edge = eff_mclk ^ mclk_q;
  assign b_rise = eff_bclk && !bclk_q;
  assign b_fall = !eff_bclk && bclk_q;
  assign lr_tick = mode_reg[voice_pkg::MD_EDGE] ? b_rise : b_fall;
  assign lcnt_next = (lcnt_reg == bdiv_reg - 8'h01) ? 8'h00 : lcnt_reg + 8'h01;

  // Edge history of the effective clocks
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) {mclk_q, bclk_q, word_select_clock_q} <= 3'h0;
    else {mclk_q, bclk_q, word_select_clock_q} <= {eff_mclk, eff_bclk, eff_word_select_clock};
  end

  // Master clock: half period of divisor system cycles
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mcnt_reg <= 8'h00;
      mclk_reg <= 1'b0;
    end else if (!rx_on || sdiv_reg == 8'h00) begin
      mcnt_reg <= 8'h00;
      mclk_reg <= !mode_reg[voice_pkg::MD_IDLE];
    end else if (mcnt_reg == sdiv_reg - 8'h01) begin
      mcnt_reg <= 8'h00;
      mclk_reg <= !mclk_reg;
    end else begin
      mcnt_reg <= mcnt_reg + 8'h01;
    end
  end

  // Bit clock: both master edges count at divisor one, else rises only
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      bcnt_reg <= 8'h00;
      bclk_reg <= 1'b0;
    end else if (!rx_on || mdiv_reg == 8'h00) begin
      bcnt_reg <= 8'h00;
      bclk_reg <= 1'b0;
    end else if (sdiv_reg == 8'h01 ? m_edge : m_rise) begin
      if (bcnt_reg == mdiv_reg - 8'h01) begin
        bcnt_reg <= 8'h00;
        bclk_reg <= !bclk_reg;
      end else begin
        bcnt_reg <= bcnt_reg + 8'h01;
      end
    end
  end

  // Word select: square wave, or one-bit frame pulse in DSP format
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      lcnt_reg <= 8'h00;
      word_select_clock_reg <= 1'b0;
    end else if (!rx_on || bdiv_reg == 8'h00) begin
      lcnt_reg <= 8'h00;
      word_select_clock_reg <= 1'b0;
    end else if (lr_tick) begin
      lcnt_reg <= lcnt_next;
      if (dsp) word_select_clock_reg <= lcnt_next == 8'h00;
      else if (lcnt_next == 8'h00) word_select_clock_reg <= !word_select_clock_reg;
    end
  end

  // Receive shifter and channel hand-off
  logic [15:0] shift_reg, rx_word;
  logic rx_left, rx_pick;
  voice_pkg::sample_t smp_reg;
  assign rx_left = (link_reg[voice_pkg::LK_FMT +: 2] == voice_pkg::FMT_I2S) ? !word_select_clock_q : word_select_clock_q;
  assign rx_pick = rx_left ? mode_reg[voice_pkg::MD_CH + 1] : mode_reg[voice_pkg::MD_CH];
  assign rx_word = rx_pick ? shift_reg : 16'h0000;

  // Word ends at each word select change; last 16 bits are kept
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_reg <= 16'h0000;
      smp_reg <= '0;
    end else begin
      if (rx_on && b_rise) shift_reg <= {shift_reg[14:0], sd2};
      smp_reg.valid <= rx_on && (eff_word_select_clock ^ word_select_clock_q) && mode_reg[voice_pkg::MD_FWD];
      if (mode_reg[voice_pkg::MD_W16]) smp_reg.data <= rx_word;
      else smp_reg.data <= {8'h00, rx_word[15:8]};
    end
  end

  // Encoder: byte pointer serialises uncompressed words
  logic [15:0] enc_in;
  logic [7:0] enc_byte, enc_lo;
  logic enc_pend, enc_ptr, push_enc, cpu_push, fill_busy;
  logic [1:0] enc_alg;
  assign enc_alg = encc_reg[voice_pkg::CC_ALG +: 2];
  always_comb begin
    if (encc_reg[voice_pkg::CC_MUTE]) enc_in = {ehi_reg, elo_reg};
    else if (encc_reg[voice_pkg::CC_W16]) enc_in = smp_reg.data;
    else enc_in = {smp_reg.data[7:0], 8'h00};
  end
  assign push_enc = enc_pend && !cpu_push && !fill_busy;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      enc_byte <= 8'h00;
      enc_lo <= 8'h00;
      enc_pend <= 1'b0;
      enc_ptr <= 1'b0;
    end else if (enc_ini) begin
      enc_pend <= 1'b0;
      enc_ptr <= 1'b0;
    end else if (push_enc) begin
      // Second byte of a plain word follows the first
      enc_pend <= enc_ptr;
      enc_byte <= enc_lo;
      enc_ptr <= 1'b0;
    end else if (!enc_pend && smp_reg.valid && encc_reg[voice_pkg::CC_RUN]) begin
      enc_pend <= 1'b1;
      enc_lo <= enc_in[7:0];
      unique case (enc_alg)
        voice_pkg::ALG_MULAW: enc_byte <= mu_enc(enc_in);
        voice_pkg::ALG_ALAW: enc_byte <= a_enc(enc_in);
        default: begin
          // Plain and adaptive codes pass the word through
          enc_byte <= enc_in[15:8];
          enc_ptr <= encc_reg[voice_pkg::CC_W16];
        end
      endcase
    end
  end

  // Decoder: loopback or receive FIFO bytes
  voice_pkg::byte_strm_t din;
  logic [15:0] dec_lin, dec_word;
  logic [7:0] dhold_reg;
  logic dptr_reg, dw16;
  logic [1:0] dec_alg;
  assign dec_alg = decc_reg[voice_pkg::CC_ALG +: 2];
  assign dw16 = decc_reg[voice_pkg::CC_W16];
  assign din = decc_reg[voice_pkg::CC_LPB] ? {push_enc, enc_byte} : i_dec_in;
  assign dec_lin = (dec_alg == voice_pkg::ALG_ALAW) ? a_dec(din.data) : mu_dec(din.data);
  assign dec_word = decc_reg[voice_pkg::CC_MUTE] ? {dhi_reg, dlo_reg} : dec_lin;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dec <= '0;
      dhold_reg <= 8'h00;
      dptr_reg <= 1'b0;
    end else begin
      o_dec.valid <= 1'b0;
      if (dec_ini) begin
        dptr_reg <= 1'b0;
      end else if (din.valid && decc_reg[voice_pkg::CC_RUN]) begin
        if (decc_reg[voice_pkg::CC_MUTE] || dec_alg == voice_pkg::ALG_MULAW ||
            dec_alg == voice_pkg::ALG_ALAW) begin
          o_dec.valid <= 1'b1;
          o_dec.data <= dw16 ? dec_word : {8'h00, dec_word[15:8]};
        end else if (!dw16) begin
          o_dec.valid <= 1'b1;
          o_dec.data <= {8'h00, din.data};
        end else if (!dptr_reg) begin
          dhold_reg <= din.data;
          dptr_reg <= 1'b1;
        end else begin
          o_dec.valid <= 1'b1;
          o_dec.data <= {dhold_reg, din.data};
          dptr_reg <= 1'b0;
        end
      end
    end
  end

  // Transmit FIFO storage and pointers
  logic [7:0] mem [128];
  logic [7:0] wp_reg, rp_reg, fifo_out, push_byte;
  logic [6:0] fcnt_reg;
  logic full, empty, cpu_pop, dma_pop, push, pop, clr, ovf_reg, udf_reg;
  logic dma_go, push_st, pop_st;
  assign full = (wp_reg ^ rp_reg) == voice_pkg::PTR_WRAP;
  assign empty = wp_reg == rp_reg;
  assign cpu_push = wr && i_req.addr == voice_pkg::A_TXF_DATA;
  assign cpu_pop = rd && i_req.addr == voice_pkg::A_TXF_DATA;
  assign clr = wr && i_req.addr == voice_pkg::A_TXF_CTL && i_req.wdata[voice_pkg::FC_CLR];
  assign dma_pop = dma_go && !cpu_pop && !empty && !fill_busy && (!o_dma.valid || i_dma_ready);
  assign push = (cpu_push || push_enc) && !fill_busy;
  assign pop = cpu_pop || dma_pop;
  assign push_byte = cpu_push ? i_req.wdata : enc_byte;
  assign fifo_out = tmute_reg ? tsil_reg : mem[rp_reg[6:0]];

  // Storage is written by a push or by the silence fill
  always_ff @(posedge i_clk_sys) begin
    if (fill_busy) mem[fcnt_reg] <= tsil_reg;
    else if (push && !full) mem[wp_reg[6:0]] <= push_byte;
  end

  // Pointers; software may also write them directly
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_reg <= 8'h00;
      rp_reg <= 8'h00;
    end else if (clr) begin
      wp_reg <= 8'h00;
      rp_reg <= 8'h00;
    end else begin
      if (wr && i_req.addr == voice_pkg::A_TXF_WP) wp_reg <= i_req.wdata;
      else if (push && !full) wp_reg <= wp_reg + 8'h01;
      if (wr && i_req.addr == voice_pkg::A_TXF_RP) rp_reg <= i_req.wdata;
      else if (pop && !empty) rp_reg <= rp_reg + 8'h01;
    end
  end

  // Fill sequencer, error flags and activity status
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      fill_busy <= 1'b0;
      fcnt_reg <= 7'h00;
      {ovf_reg, udf_reg, push_st, pop_st} <= 4'h0;
    end else begin
      if (wr && i_req.addr == voice_pkg::A_TXF_CTL && i_req.wdata[voice_pkg::FC_FILL]) begin
        fill_busy <= 1'b1;
        fcnt_reg <= 7'h00;
      end else if (fill_busy) begin
        fill_busy <= fcnt_reg != voice_pkg::FILL_LAST;
        fcnt_reg <= fcnt_reg + 7'h01;
      end
      // A new error wins over a clear in the same cycle
      ovf_reg <= (push && full) || (ovf_reg && !clr);
      udf_reg <= (pop && empty) || (udf_reg && !clr);
      push_st <= push;
      pop_st <= pop;
    end
  end

  // DMA drain towards the MAC; go bit drops once empty
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      dma_go <= 1'b0;
      o_dma <= '0;
    end else begin
      if (wr && i_req.addr == voice_pkg::A_TXF_CTL && i_req.wdata[voice_pkg::FC_DMA]) dma_go <= 1'b1;
      else if (dma_go && empty && (!o_dma.valid || i_dma_ready)) dma_go <= 1'b0;
      if (dma_pop) o_dma <= {1'b1, fifo_out};
      else if (i_dma_ready) o_dma.valid <= 1'b0;
    end
  end

  // Read data stands one cycle only; unmapped reads give zero
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) o_rdata <= 8'h00;
    else if (!rd) o_rdata <= 8'h00;
    else begin
      unique case (i_req.addr)
        voice_pkg::A_RX_LINK: o_rdata <= link_reg;
        voice_pkg::A_RX_SDIV: o_rdata <= sdiv_reg;
        voice_pkg::A_RX_MDIV: o_rdata <= mdiv_reg;
        voice_pkg::A_RX_BDIV: o_rdata <= bdiv_reg;
        voice_pkg::A_RX_MODE: o_rdata <= mode_reg;
        voice_pkg::A_ENC_CTL: o_rdata <= encc_reg;
        voice_pkg::A_ENC_SHI: o_rdata <= ehi_reg;
        voice_pkg::A_ENC_SLO: o_rdata <= elo_reg;
        voice_pkg::A_DEC_CTL: o_rdata <= decc_reg;
        voice_pkg::A_DEC_SHI: o_rdata <= dhi_reg;
        voice_pkg::A_DEC_SLO: o_rdata <= dlo_reg;
        voice_pkg::A_TXF_DATA: o_rdata <= fifo_out;
        voice_pkg::A_TXF_SIL: o_rdata <= tsil_reg;
        voice_pkg::A_TXF_CTL: o_rdata <= {5'h00, tmute_reg, 2'h0};
        voice_pkg::A_TXF_RP: o_rdata <= rp_reg;
        voice_pkg::A_TXF_WP: o_rdata <= wp_reg;
        voice_pkg::A_TXF_FLAGS: o_rdata <= {4'h0, full, empty, ovf_reg, udf_reg};
        voice_pkg::A_TXF_STS: o_rdata <= {3'h0, fill_busy, push_st, pop_st, 2'h0};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // Clock pins are driven only as link master
  assign o_clk = {mclk_reg, bclk_reg, word_select_clock_reg};
  assign o_clk_oe = master;

  // Checks
  sequence fill_cmd;
    wr && i_req.addr == voice_pkg::A_TXF_CTL && i_req.wdata[voice_pkg::FC_FILL];
  endsequence
  sequence mclk_fast;
    rx_on && sdiv_reg == 8'h01 && !wr;
  endsequence
  AST_MCLK_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !rx_on ##1 !rx_on |-> mclk_reg == !$past(mode_reg[voice_pkg::MD_IDLE])) else $error("mclk not idle");
  AST_MCLK_DIV1: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    mclk_fast ##1 mclk_fast |-> $changed(mclk_reg)) else $error("mclk not toggling");
  AST_BCLK_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    mdiv_reg == 8'h00 |=> !bclk_reg) else $error("bclk with zero divisor");
  AST_WORD_SELECT_CLOCK_EDGE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    rx_on && $changed(word_select_clock_reg) |-> $past(lr_tick)) else $error("word_select_clock off edge");
  AST_SHARE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    share |=> bclk_q == $past(i_tx_clk.bclk)) else $error("shared bclk not used");
  AST_FWD_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !mode_reg[voice_pkg::MD_FWD] |=> !smp_reg.valid) else $error("sample passed");
  AST_FILL: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    fill_cmd |=> fill_busy [*8]) else $error("fill ended early");
  AST_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    clr |=> wp_reg == 8'h00 && rp_reg == 8'h00) else $error("clear failed");
  AST_UDF: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    cpu_pop && empty |=> udf_reg) else $error("underflow missed");
  AST_DMA_END: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    dma_go && empty && !o_dma.valid && !wr |=> !dma_go) else $error("dma go stuck");
endmodule // voice_capture_codec_path

// file: voice_capture_codec_path_tb_top.sv
module voice_capture_codec_path_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0; // System clock
  logic rstn = 1'b0; // Active low reset
  voice_pkg::reg_req_t req = '0; // Register bus request
  logic sdata; // Serial data from the converter
  logic ready = 1'b0; // Random MAC stalls
  logic [7:0] rdata;
  voice_pkg::i2s_clk_t lk;
  voice_pkg::byte_strm_t dma;
  voice_pkg::i2s_clk_t txc = '0; // Transmit block clocks, random
  voice_pkg::sample_t dec; // Decoder output
  logic oe; // Clock pin drive enable
  logic [15:0] dec_exp = 16'h0000; // Expected loopback word
  int n_dec = 0; // Decoder words seen
  logic [31:0] rng = 32'hae278e51;
  logic [7:0] rq[$]; // Expected read data
  logic [7:0] dq[$]; // Expected DMA bytes
  logic rd_seen = 1'b0;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  voice_capture_codec_path voice_capture_codec_path_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_req(req),
    .i_tx_clk(txc), .i_ext_bclk(1'b0), .i_ext_word_select_clock(1'b0), .i_adc_sdata(sdata), .i_dec_in('0),
    .i_dma_ready(ready), .o_rdata(rdata), .o_clk(lk), .o_clk_oe(oe), .o_dma(dma), .o_dec(dec));
  adc_model adc_model_inst (.i_bclk(lk.bclk), .i_word_select_clock(lk.word_select_clock), .o_sdata(sdata));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One-cycle strobes, released at the following edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    rq.push_back(e);
    @(posedge clk);
    req.rd <= 1'b0;
  endtask
  // Watcher: read data one cycle after the strobe, DMA bytes on handshake
  always @(posedge clk) begin
    rd_seen <= req.rd;
    rng <= xs(rng);
    ready <= rng[3] | rng[7];
    txc <= rng[10:8];
    cyc <= cyc + 1;
    if (rd_seen) check(rdata, rq.pop_front());
    if (dma.valid === 1'b1 && ready) check(dma.data, dq.pop_front());
    // Every decoded word in loopback is the encoder silence word
    if (dec.valid === 1'b1) begin
      n_dec <= n_dec + 1;
      check(dec.data[15:8], dec_exp[15:8]);
      check(dec.data[7:0], dec_exp[7:0]);
    end
    if (cyc == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] b[3];
    logic [7:0] s;
    int n;
    logic m;
    logic [15:0] ev;
    int nb;
    int nl;
    logic mb;
    logic ml;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(voice_pkg::A_RX_SDIV, 8'h00);
    rd(voice_pkg::A_RX_MDIV, 8'h00);
    rd(voice_pkg::A_RX_BDIV, 8'h00);
    rd(voice_pkg::A_RX_MODE, 8'h7e);
    rd(voice_pkg::A_TXF_RP, 8'h00);
    rd(16'h2700, 8'h00);
    check({7'h00, oe}, 8'h01);
    s = rng[7:0];
    wr(voice_pkg::A_TXF_SIL, s);
    for (int i = 0; i < 3; i++) begin
      b[i] = rng[15:8];
      wr(voice_pkg::A_TXF_DATA, b[i]);
    end
    rd(voice_pkg::A_TXF_WP, 8'h03);
    for (int i = 0; i < 3; i++) rd(voice_pkg::A_TXF_DATA, b[i]);
    rd(voice_pkg::A_TXF_RP, 8'h03);
    wr(voice_pkg::A_TXF_CTL, 8'h04);
    rd(voice_pkg::A_TXF_CTL, 8'h04);
    rd(voice_pkg::A_TXF_DATA, s);
    wr(voice_pkg::A_TXF_CTL, 8'h02);
    rd(voice_pkg::A_TXF_RP, 8'h00);
    rd(voice_pkg::A_TXF_FLAGS, 8'h04);
    wr(voice_pkg::A_TXF_CTL, 8'h01);
    rd(voice_pkg::A_TXF_STS, 8'h10);
    repeat (140) @(posedge clk);
    rd(voice_pkg::A_TXF_STS, 8'h00);
    wr(voice_pkg::A_TXF_CTL, 8'h02);
    for (int i = 0; i < 4; i++) begin
      dq.push_back(rng[23:16]);
      wr(voice_pkg::A_TXF_DATA, dq[i]);
    end
    wr(voice_pkg::A_TXF_CTL, 8'h08);
    for (int i = 0; i < 300 && dq.size() > 0; i++) @(posedge clk);
    rd(voice_pkg::A_TXF_CTL, 8'h00);
    // Go bit must have dropped: a late byte stays in the FIFO
    wr(voice_pkg::A_TXF_DATA, 8'h5a);
    repeat (4) @(posedge clk);
    rd(voice_pkg::A_TXF_RP, 8'h04);
    // Encoder silence word looped through plain coding into the decoder
    ev = rng[15:0];
    dec_exp = ev;
    wr(voice_pkg::A_TXF_CTL, 8'h02);
    wr(voice_pkg::A_ENC_SHI, ev[15:8]);
    wr(voice_pkg::A_ENC_SLO, ev[7:0]);
    wr(voice_pkg::A_DEC_CTL, 8'ha1);
    wr(voice_pkg::A_ENC_CTL, 8'h31);
    // Fastest link: master clock flips every system cycle
    wr(voice_pkg::A_RX_SDIV, 8'h01);
    wr(voice_pkg::A_RX_MDIV, 8'h01);
    wr(voice_pkg::A_RX_BDIV, 8'h10);
    wr(voice_pkg::A_RX_MODE, 8'h7f);
    n = 0;
    nb = 0;
    nl = 0;
    m = lk.mclk;
    mb = lk.bclk;
    ml = lk.word_select_clock;
    repeat (128) begin
      @(negedge clk);
      if (lk.mclk !== m) n++;
      if (lk.bclk !== mb) nb++;
      if (lk.word_select_clock !== ml) nl++;
      m = lk.mclk;
      mb = lk.bclk;
      ml = lk.word_select_clock;
    end
    check({7'h00, n >= 126}, 8'h01);
    check({7'h00, nb >= 125}, 8'h01);
    check({7'h00, nl >= 3 && nl <= 4}, 8'h01);
    wr(voice_pkg::A_RX_MODE, 8'h7e);
    repeat (4) @(negedge clk);
    check({7'h00, lk.mclk}, 8'h00);
    // Encoder bytes land in the FIFO high byte first
    wr(voice_pkg::A_ENC_CTL, 8'h00);
    rd(voice_pkg::A_TXF_DATA, ev[15:8]);
    rd(voice_pkg::A_TXF_DATA, ev[7:0]);
    check({7'h00, n_dec > 0}, 8'h01);
    // Idle high, forwarding off
    wr(voice_pkg::A_RX_MODE, 8'h36);
    repeat (4) @(negedge clk);
    check({7'h00, lk.mclk}, 8'h01);
    // Slave sharing the transmit clocks releases the clock pins
    wr(voice_pkg::A_RX_LINK, 8'h40);
    wr(voice_pkg::A_RX_MODE, 8'hb6);
    repeat (8) @(negedge clk);
    check({7'h00, oe}, 8'h00);
    tally_and_finish();
  end
endmodule // voice_capture_codec_path_tb_top

// file: voice_pkg.sv
package voice_pkg;
  // Register byte addresses
  localparam logic [15:0] A_RX_LINK = 16'h2538;
  localparam logic [15:0] A_RX_SDIV = 16'h253a;
  localparam logic [15:0] A_RX_MDIV = 16'h253b;
  localparam logic [15:0] A_RX_BDIV = 16'h253c;
  localparam logic [15:0] A_RX_MODE = 16'h253d;
  localparam logic [15:0] A_ENC_CTL = 16'h2745;
  localparam logic [15:0] A_ENC_SHI = 16'h2746;
  localparam logic [15:0] A_ENC_SLO = 16'h2747;
  localparam logic [15:0] A_DEC_CTL = 16'h274d;
  localparam logic [15:0] A_DEC_SHI = 16'h274e;
  localparam logic [15:0] A_DEC_SLO = 16'h274f;
  localparam logic [15:0] A_TXF_DATA = 16'h2750;
  localparam logic [15:0] A_TXF_SIL = 16'h2751;
  localparam logic [15:0] A_TXF_CTL = 16'h2752;
  localparam logic [15:0] A_TXF_RP = 16'h2753;
  localparam logic [15:0] A_TXF_WP = 16'h2754;
  localparam logic [15:0] A_TXF_FLAGS = 16'h2759;
  localparam logic [15:0] A_TXF_STS = 16'h275a;
  // Link format register fields
  localparam int LK_MASTER = 7;
  localparam int LK_FMT = 5;
  // Receive mode register fields
  localparam int MD_SHARE = 7;
  localparam int MD_IDLE = 6;
  localparam int MD_EDGE = 5;
  localparam int MD_W16 = 4;
  localparam int MD_FWD = 3;
  localparam int MD_CH = 1;
  localparam int MD_ON = 0;
  // Encoder and decoder control fields
  localparam int CC_LPB = 7;
  localparam int CC_W16 = 5;
  localparam int CC_MUTE = 4;
  localparam int CC_ALG = 2;
  localparam int CC_INI = 1;
  localparam int CC_RUN = 0;
  // FIFO control, status and flag fields
  localparam int FC_DMA = 3;
  localparam int FC_MUTE = 2;
  localparam int FC_CLR = 1;
  localparam int FC_FILL = 0;
  localparam int ST_FILL = 4;
  localparam int ST_PUSH = 3;
  localparam int ST_POP = 2;
  // Reset values
  localparam logic [7:0] RST_LINK = 8'hc0;
  localparam logic [7:0] RST_MODE = 8'h7e;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Encodings
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_DSP = 2'h3;
  localparam logic [1:0] ALG_MULAW = 2'h1;
  localparam logic [1:0] ALG_ALAW = 2'h2;
  // FIFO geometry and companding constants
  localparam logic [7:0] PTR_WRAP = 8'h80;
  localparam logic [6:0] FILL_LAST = 7'h7f;
  localparam logic [13:0] MU_CLIP = 14'h1fde;
  localparam logic [13:0] MU_ADD = 14'h0021;
  localparam logic [15:0] MU_BIAS = 16'h0084;
  localparam logic [7:0] A_XOR = 8'h55;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic mclk;
    logic bclk;
    logic word_select_clock;
  } i2s_clk_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_strm_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sample_t;
endpackage
